// [rtl/sdram_consts.vh]
// Constants for the synchronous DRAM mode register and command decoding
`ifndef SDRAM_CONSTS_VH
`define SDRAM_CONSTS_VH
`define MODE_RESET      12'h000
`define LEN_FIELD_LSB   0
`define LEN_FIELD_MSB   2
`define ORDER_BIT       3
`define LAT_FIELD_LSB   4
`define LAT_FIELD_MSB   6
`define WM_LSB          9
`define WM_MSB          11
`define LEN_CODE_1      3'h0
`define LEN_CODE_2      3'h1
`define LEN_CODE_4      3'h2
`define LEN_CODE_8      3'h3
`define LEN_CODE_PAGE   3'h7
`define LEN_1           9'h001
`define LEN_2           9'h002
`define LEN_4           9'h004
`define LEN_8           9'h008
`define LEN_PAGE        9'h100
`define LAT_CODE_2      3'h2
`define LAT_CODE_3      3'h3
`define WM_BURST        3'h0
`define WM_SINGLE       3'h1
`define CMD_MRS         3'h0
`define CMD_REF         3'h1
`define CMD_PRE         3'h2
`define CMD_ACT         3'h3
`define CMD_WRITE       3'h4
`define CMD_READ        3'h5
`define CMD_BST         3'h6
`define CMD_NOP         3'h7
`define ALL_BANKS_BIT   10
`define BANK_BIT        11
`define COL_MSB         7
`define REF_NEEDED      2'h2
`define FIFO_WIDTH      27
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define WF_UPPER_EN     26
`define WF_LOWER_EN     25
`define WF_ADDR_MSB     24
`define WF_ADDR_LSB     16
`define HI_BYTE_MSB     15
`define HI_BYTE_LSB     8
`define LO_BYTE_MSB     7
`define LO_BYTE_LSB     0
`endif

// [rtl/sdram_mode_core.v]
// Synchronous DRAM device core: init tracking, mode register, burst engine, write FIFO
`timescale 1ns/1ps
`include "sdram_consts.vh"

// Write FIFO with valid/ready on both sides
module write_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // Honest full and empty flags
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and occupancy update
  always @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Storage write
  always @(posedge mclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

// Functional notes
// (RQ1) Controller holds clock gate and byte masks high 100 us before init.
// (RQ2) Controller precharges both banks first after the hold period.
// (RQ3) Controller issues two or more auto-refreshes, then a mode register set.
// (RQ4) Mode register set may precede the refreshes; device accepts either order.
// (RQ5) Mode register set loads all twelve address lines as the mode code.
// (RQ6) Code fields: write mode 11:9, latency 6:4, ordering 3, length 2:0.
// (RQ7) Controller sets the mode register only with both banks idle.
// (RQ8) Controller waits two cycles after a mode register set.
// (RQ9) First read data appears the programmed latency after the read command.
// (RQ10) Burst starts at given column; following columns generated internally.
// (RQ11) Length codes 000,001,010,011,111 give 1,2,4,8,full page.
// (RQ12) Ordering bit 0 sequential, 1 interleaved, for reads and writes; code runs full page bursts sequential with either bit.
// (RQ13) Write mode 000 bursts writes; first data taken with the command.
// (RQ14) Write start comes from column and bank lines in the command cycle.
// (RQ15) Write mode 001 writes one column; reads keep programmed length.
// (RQ16) Latency code 010 gives two cycles, 011 gives three.
// (RQ17) Full page burst covers 256 columns, wrapping from start column.
// (RQ18) Controller programs only defined field codes.
// (RQ19) Controller waits for full init before access commands.
module sdram_mode_core (
  input  wire        mclk,
  input  wire        reset,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [11:0] addr,
  input  wire [1:0]  dqm,
  input  wire [15:0] dq_in,
  output wire [15:0] dq_out,
  output wire        dq_oe,
  output wire        init_done,
  output wire        wdata_ready,
  output wire [11:0] mode_word
);
  reg  [11:0] operating_mode_word;
  reg         precharged;
  reg  [1:0]  refresh_count;
  reg         mode_loaded;
  reg         busy;
  reg         busy_rd;
  reg         bank_q;
  reg  [7:0]  start_q;
  reg  [7:0]  beat_idx;
  reg  [8:0]  len_q;
  reg  [15:0] pipe_d0;
  reg  [15:0] pipe_d1;
  reg  [15:0] pipe_d2;
  reg         pipe_v0;
  reg         pipe_v1;
  reg         pipe_v2;
  reg  [15:0] mem [0:511];
  reg  [8:0]  len_dec;
  wire [2:0]  cmd;
  wire        cmd_valid;
  wire        cmd_rd;
  wire        cmd_wr;
  wire        stop;
  wire [2:0]  burst_count_field;
  wire        burst_order_field;
  wire [2:0]  latency_select_field;
  wire [2:0]  write_mode;
  wire [7:0]  beat_col;
  wire        beat_bank;
  wire        rd_beat;
  wire        wr_beat;
  wire [8:0]  burst_len;
  wire [8:0]  idx_next;
  wire [26:0] fifo_out;
  wire        bank_select_line;
  wire        fifo_out_valid;
  wire        drain;

  // Column for beat i of a burst from start s
  function [7:0] burst_col;
    input [7:0] s;
    input [7:0] i;
    input [2:0] len_code;
    input       interleave;
    reg   [7:0] m;
    reg   [7:0] sum;
    begin
      case (len_code)
        `LEN_CODE_2:    m = 8'h01;
        `LEN_CODE_4:    m = 8'h03;
        `LEN_CODE_8:    m = 8'h07;
        `LEN_CODE_PAGE: m = 8'hff;
        default:        m = 8'h00;
      endcase
      sum = s + i;
      if (interleave && (len_code != `LEN_CODE_PAGE)) begin
        burst_col = (s & ~m) | ((s ^ i) & m); // RQ12
      end else begin
        burst_col = (s & ~m) | (sum & m); // RQ12 RQ17
      end
    end
  endfunction

  // Command decode and mode fields
  assign cmd                  = {ras_n, cas_n, we_n};
  assign cmd_valid            = cke & ~cs_n;
  assign cmd_rd               = cmd_valid & (cmd == `CMD_READ);
  assign cmd_wr               = cmd_valid & (cmd == `CMD_WRITE);
  assign stop                 = cmd_valid & ((cmd == `CMD_BST) | (cmd == `CMD_PRE));
  assign bank_select_line     = addr[`BANK_BIT]; // RQ14
  assign burst_count_field    = operating_mode_word[`LEN_FIELD_MSB:`LEN_FIELD_LSB]; // RQ6
  assign burst_order_field    = operating_mode_word[`ORDER_BIT]; // RQ6
  assign latency_select_field = operating_mode_word[`LAT_FIELD_MSB:`LAT_FIELD_LSB]; // RQ6
  assign write_mode           = operating_mode_word[`WM_MSB:`WM_LSB]; // RQ6
  assign mode_word            = operating_mode_word;
  assign init_done            = precharged & mode_loaded & (refresh_count == `REF_NEEDED);

  // Burst length decode
  always @* begin
    case (burst_count_field)
      `LEN_CODE_1:    len_dec = `LEN_1; // RQ11
      `LEN_CODE_2:    len_dec = `LEN_2; // RQ11
      `LEN_CODE_4:    len_dec = `LEN_4; // RQ11
      `LEN_CODE_8:    len_dec = `LEN_8; // RQ11
      `LEN_CODE_PAGE: len_dec = `LEN_PAGE; // RQ11 RQ17
      default:        len_dec = `LEN_1;
    endcase
  end

  // Single write ignores length; reads keep it
  assign burst_len = (cmd_wr && (write_mode == `WM_SINGLE)) ? `LEN_1 : len_dec; // RQ15 RQ13

  // Beat address: command cycle takes pins, later beats generated
  assign beat_col  = (cmd_rd | cmd_wr) ? addr[`COL_MSB:0]
                   : burst_col(start_q, beat_idx, burst_count_field, burst_order_field); // RQ10 RQ14
  assign beat_bank = (cmd_rd | cmd_wr) ? bank_select_line : bank_q; // RQ14
  assign rd_beat   = cmd_rd | (busy & busy_rd & ~stop & ~cmd_wr);
  assign wr_beat   = cmd_wr | (busy & ~busy_rd & ~stop & ~cmd_rd); // RQ13
  assign idx_next  = {1'b0, beat_idx} + 9'h001;

  // Init tracking and mode register load
  always @(posedge mclk) begin
    if (reset) begin
      operating_mode_word <= `MODE_RESET;
      precharged          <= 1'b0;
      refresh_count       <= 2'h0;
      mode_loaded         <= 1'b0;
    end else if (cmd_valid) begin
      if ((cmd == `CMD_PRE) && addr[`ALL_BANKS_BIT]) begin
        precharged <= 1'b1;
      end
      // Refreshes counted whether before or after the mode set
      if ((cmd == `CMD_REF) && precharged && (refresh_count != `REF_NEEDED)) begin
        refresh_count <= refresh_count + 2'h1; // RQ4
      end
      if (cmd == `CMD_MRS) begin
        operating_mode_word <= addr; // RQ5
        mode_loaded         <= 1'b1; // RQ4
      end
    end
  end

  // Burst sequencer
  always @(posedge mclk) begin
    if (reset) begin
      busy     <= 1'b0;
      busy_rd  <= 1'b0;
      bank_q   <= 1'b0;
      start_q  <= 8'h00;
      beat_idx <= 8'h00;
      len_q    <= `LEN_1;
    end else if (cmd_rd | cmd_wr) begin
      busy     <= (burst_len != `LEN_1); // RQ10
      busy_rd  <= cmd_rd;
      bank_q   <= bank_select_line; // RQ14
      start_q  <= addr[`COL_MSB:0];
      beat_idx <= 8'h01;
      len_q    <= burst_len;
    end else if (stop) begin
      busy <= 1'b0;
    end else if (busy) begin
      beat_idx <= idx_next[7:0];
      if (idx_next == len_q) begin
        busy <= 1'b0; // RQ10
      end
    end
  end

  // Write beats queue through the FIFO; reads own the array
  assign drain = ~rd_beat;
  write_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_wfifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   ({~dqm, beat_bank, beat_col, dq_in}),
    .in_valid  (wr_beat),
    .in_ready  (wdata_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (drain)
  );

  // Array write with byte lanes
  always @(posedge mclk) begin
    if (fifo_out_valid && drain) begin
      if (fifo_out[`WF_UPPER_EN]) begin
        mem[fifo_out[`WF_ADDR_MSB:`WF_ADDR_LSB]][`HI_BYTE_MSB:`HI_BYTE_LSB] <= fifo_out[`HI_BYTE_MSB:`HI_BYTE_LSB];
      end
      if (fifo_out[`WF_LOWER_EN]) begin
        mem[fifo_out[`WF_ADDR_MSB:`WF_ADDR_LSB]][`LO_BYTE_MSB:`LO_BYTE_LSB] <= fifo_out[`LO_BYTE_MSB:`LO_BYTE_LSB];
      end
    end
  end

  // Read latency pipeline
  always @(posedge mclk) begin
    if (reset) begin
      pipe_v0 <= 1'b0;
      pipe_v1 <= 1'b0;
      pipe_v2 <= 1'b0;
      pipe_d0 <= 16'h0000;
      pipe_d1 <= 16'h0000;
      pipe_d2 <= 16'h0000;
    end else begin
      pipe_v0 <= rd_beat;
      pipe_d0 <= rd_beat ? mem[{beat_bank, beat_col}] : 16'h0000; // Zero between bursts
      pipe_v1 <= pipe_v0;
      pipe_d1 <= pipe_d0;
      pipe_v2 <= pipe_v1;
      pipe_d2 <= pipe_d1;
    end
  end

  // Tap chosen by latency field: two or three cycles
  assign dq_out = (latency_select_field == `LAT_CODE_3) ? pipe_d2 : pipe_d1; // RQ9 RQ16
  assign dq_oe  = (latency_select_field == `LAT_CODE_3) ? pipe_v2 : pipe_v1; // RQ9 RQ16
endmodule

// [dv/sdram_mode_core_properties.sv]
// Port assertions for the device core
`timescale 1ns/1ps
`include "sdram_consts.vh"
module sdram_mode_core_properties (
  input wire        mclk,
  input wire        reset,
  input wire        cke,
  input wire        cs_n,
  input wire        ras_n,
  input wire        cas_n,
  input wire        we_n,
  input wire [11:0] addr,
  input wire        dq_oe,
  input wire        init_done,
  input wire [11:0] mode_word
);
  // Command decode
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire       sel = cke && !cs_n;
  wire       rd  = sel && cmd == `CMD_READ;
  wire       mrs = sel && cmd == `CMD_MRS;
  wire       nop = !sel || cmd == `CMD_NOP;
  wire       cl3 = mode_word[`LAT_FIELD_MSB:`LAT_FIELD_LSB] == `LAT_CODE_3;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_mode_load: assert property (mrs |=> mode_word == $past(addr))
    else $error("mode load");
  chk_mode_hold: assert property (!mrs |=> $stable(mode_word))
    else $error("mode hold");
  chk_lat_two: assert property (rd && !cl3 |-> ##2 dq_oe)
    else $error("latency two");
  chk_lat_three: assert property (rd && cl3 |=> ##2 dq_oe)
    else $error("latency three");
  chk_oe_cause: assert property ($rose(dq_oe) |-> $past(rd, 2) || $past(rd, 3))
    else $error("stray data");
  chk_burst_four: assert property (rd && mode_word[2:0] == `LEN_CODE_4 && !cl3 ##1 nop[*4] |-> dq_oe ##1 dq_oe ##1 !dq_oe)
    else $error("burst four");
  chk_burst_one: assert property (rd && mode_word[2:0] == `LEN_CODE_1 && cl3 ##1 nop[*3] |-> dq_oe ##1 !dq_oe)
    else $error("burst one");
  chk_init_hold: assert property (init_done |=> init_done)
    else $error("init lost");
  cover property (mrs ##1 nop ##1 nop);
  cover property (rd && mode_word[2:0] == `LEN_CODE_PAGE);
  cover property ($rose(init_done));
endmodule

// [dv/ctrl_model.sv]
// Controller model issuing commands to the device core
`timescale 1ns/1ps
`include "sdram_consts.vh"
module ctrl_model (
  input  wire        mclk,
  output reg         cke,
  output reg         cs_n,
  output reg  [2:0]  cmd,
  output reg  [11:0] addr,
  output reg  [1:0]  dqm,
  output reg  [15:0] dq_in
);
  // Bus at time zero
  initial begin
    cke = 1'b1;
    cs_n = 1'b0;
    cmd = `CMD_NOP;
    addr = 12'h000;
    dqm = 2'h3;
    dq_in = 16'h0000;
  end
  // One command per rising edge
  task step(input [2:0] c, input [11:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      cmd <= c;
      addr <= a;
      dq_in <= d;
    end
  endtask
  // Idle cycles, released lines toggle
  task idle(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) step(`CMD_NOP, ~addr, ~dq_in);
    end
  endtask
  // One write beat with byte masks, masks cleared on the next edge
  task write_masked(input [11:0] a, input [15:0] d, input [1:0] m);
    begin
      step(`CMD_WRITE, a, d);
      dqm <= m;
      step(`CMD_NOP, a, d);
      dqm <= 2'h0;
    end
  endtask
  // Mode set with banks idle, then two quiet cycles
  task set_mode(input [11:0] m);
    begin
      step(`CMD_MRS, m, ~dq_in);
      idle(2);
    end
  endtask
  // Power-on order, mode set before or after refreshes
  task init_seq(input [11:0] m, input first);
    begin
      dqm <= 2'h3;
      idle(2500);
      step(`CMD_PRE, 12'h400, ~dq_in);
      dqm <= 2'h0;
      if (first) set_mode(m);
      step(`CMD_REF, 12'h000, ~dq_in);
      step(`CMD_REF, 12'h000, ~dq_in);
      if (!first) set_mode(m);
      idle(2);
    end
  endtask
endmodule

// [dv/sdram_mode_core_tb.sv]
// Self-checking bench for the device core
`timescale 1ns/1ps
`include "sdram_consts.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sdram_mode_core_tb;
  reg         mclk;
  reg         reset;
  wire        cke;
  wire        cs_n;
  wire        dq_oe;
  wire        init_done;
  wire        wdata_ready;
  wire [2:0]  cmd;
  wire [1:0]  dqm;
  wire [11:0] addr;
  wire [11:0] mode_word;
  wire [15:0] dq_in;
  wire [15:0] dq_out;
  integer     num_errors;
  integer     checks;
  integer     i;
  ctrl_model i_ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  sdram_mode_core i_dut (.mclk(mclk), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
    .we_n(cmd[0]), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .init_done(init_done), .wdata_ready(wdata_ready), .mode_word(mode_word));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task test_done;
    begin
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task t_reset;
    begin
      @(posedge mclk);
      reset <= 1'b1;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK(mode_word, 12'h000)
      `CHK(init_done, 1'b0)
    end
  endtask
  task t_init(input [11:0] m, input first);
    begin
      i_ctl.init_seq(m, first);
      #1;
      `CHK(init_done, 1'b1)
      `CHK(mode_word, m)
    end
  endtask
  // Read burst: latency, then each beat's column
  task rd(input [11:0] m, input [11:0] a, input integer n, input [3:0] hi);
    integer   k;
    reg [7:0] c;
    reg [7:0] msk;
    begin
      i_ctl.set_mode(m);
      msk = n[7:0] - 8'h01;
      i_ctl.step(`CMD_READ, a, 16'h0000);
      k = 0;
      do begin
        i_ctl.idle(1);
        #1;
        k = k + 1;
      end while (dq_oe !== 1'b1 && k < 9);
      `CHK(k, (m[6:4] == `LAT_CODE_3) ? 3 : 2)
      if (k >= 9) test_done;
      for (k = 0; k < n; k = k + 1) begin
        c = m[3] ? a[7:0] ^ k[7:0] : a[7:0] + k[7:0];
        c = (a[7:0] & ~msk) | (c & msk);
        `CHK(dq_out, {hi, 4'h0, c})
        i_ctl.idle(1);
        #1;
      end
      `CHK(dq_oe, 1'b0)
    end
  endtask
  // Single writes under a burst-of-eight setting
  task t_fill;
    begin
      for (i = 0; i < 256; i = i + 1) i_ctl.step(`CMD_WRITE, i[11:0], {8'ha0, i[7:0]});
      i_ctl.step(`CMD_WRITE, 12'h805, 16'hb005);
      i_ctl.idle(12);
      #1;
      `CHK(wdata_ready, 1'b1)
    end
  endtask
  // Byte masks on single writes, then a burst cut by burst stop
  task t_mask_stop;
    begin
      i_ctl.set_mode(12'h220);
      i_ctl.write_masked(12'h010, 16'h5566, 2'h2);
      i_ctl.write_masked(12'h011, 16'h7788, 2'h1);
      i_ctl.set_mode(12'h021);
      i_ctl.step(`CMD_READ, 12'h010, 16'h0000);
      i_ctl.idle(2);
      #1;
      `CHK(dq_out, 16'ha066)
      i_ctl.idle(1);
      #1;
      `CHK(dq_out, 16'h7711)
      i_ctl.set_mode(12'h023);
      i_ctl.step(`CMD_READ, 12'h010, 16'h0000);
      i_ctl.step(`CMD_BST, 12'h000, 16'h0000);
      i_ctl.idle(1);
      #1;
      `CHK(dq_out, 16'ha066)
      i_ctl.idle(1);
      #1;
      `CHK(dq_oe, 1'b0)
    end
  endtask
  // Burst write from mid-block, data with the command
  task t_burst_write;
    begin
      i_ctl.set_mode(12'h022);
      i_ctl.step(`CMD_WRITE, 12'h042, 16'hc042);
      i_ctl.step(`CMD_NOP, 12'h000, 16'hc043);
      i_ctl.step(`CMD_NOP, 12'h000, 16'hc040);
      i_ctl.step(`CMD_NOP, 12'h000, 16'hc041);
      i_ctl.idle(12);
      rd(12'h022, 12'h040, 4, 4'hc);
    end
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    num_errors = 0;
    checks = 0;
    t_reset;
    t_init(12'h223, 1'b1);
    t_fill;
    rd(12'h223, 12'h005, 8, 4'ha);
    rd(12'h03b, 12'h00d, 8, 4'ha);
    rd(12'h02a, 12'h007, 4, 4'ha);
    rd(12'h021, 12'h013, 2, 4'ha);
    rd(12'h030, 12'h805, 1, 4'hb);
    rd(12'h027, 12'h0fd, 256, 4'ha);
    t_burst_write;
    t_mask_stop;
    t_reset;
    t_init(12'h032, 1'b0);
    test_done;
  end
endmodule
bind sdram_mode_core sdram_mode_core_properties i_chk (.mclk(mclk), .reset(reset), .cke(cke), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .dq_oe(dq_oe), .init_done(init_done),
  .mode_word(mode_word));
